// ==== design/dmari_pkg.sv ====
/*
  Package for the reload and indirect-address DMA channel: register offsets,
  control field positions, reset values, enumerations and bus carriers.
  Assumes one 25 MHz clock and an AXI4-Lite register port.
*/
// Overview of operation
// - With reload on, source address returns to its start after every four transfers.
// - With reload on, the channel stops and drops its bus request after each group.
// - With reload off, transfers continue past four, bus held in burst mode, source keeps stepping.
// - Destination address steps by its own mode regardless of reload.
// - In burst mode the bus is kept and transfers run back to back until the count ends or, with reload on, the group ends.
// - A reload group end before count zero clears the request flag, no interrupt.
// - Count reaching zero with interrupt enable set raises end-of-transfer interrupt.
// - Count reaching zero clears the requesting peripheral's flag.
// - Indirect mode reads a pointer at source, reads data there, writes destination.
// - The indirect pointer fetch is always a longword access.
// - Indirect mode steps source by its step mode, by four, following the pointer.
// - Indirect mode write phase equals the ordinary dual-address write.
package dmari_pkg;

  localparam logic [7:0] SRC_ADDR_OFS  = 8'h00;
  localparam logic [7:0] DST_ADDR_OFS  = 8'h04;
  localparam logic [7:0] COUNT_OFS     = 8'h08;
  localparam logic [7:0] CTRL_OFS      = 8'h0C;
  localparam logic [7:0] OPER_OFS      = 8'h10;

  // Channel control fields
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_IE_BIT      = 2;
  localparam int CTRL_DONE_BIT    = 1;
  localparam int CTRL_TS_LO_BIT   = 3;
  localparam int CTRL_TS_HI_BIT   = 4;
  localparam int CTRL_BURST_BIT   = 5;
  localparam int CTRL_RELOAD_BIT  = 6;
  localparam int CTRL_INDIR_BIT   = 7;
  localparam int CTRL_DM_LO_BIT   = 8;
  localparam int CTRL_DM_HI_BIT   = 9;
  localparam int CTRL_SM_LO_BIT   = 10;
  localparam int CTRL_SM_HI_BIT   = 11;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0FFD;
  localparam int OPER_MASTER_BIT  = 0;

  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE   = 32'h0000_0001;
  localparam logic [1:0]  GROUP_LAST  = 2'h3;
  localparam logic [1:0]  GROUP_ZERO  = 2'h0;
  localparam logic [2:0]  SIZE_LONG   = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {STEP_FIXED, STEP_INC, STEP_DEC, STEP_RSVD} dmari_step_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_LINE} dmari_size_e;

  // System bus request toward memory/peripheral
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } dmari_mreq_s;

  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } dmari_mrsp_s;

endpackage

// ==== design/dmari_channel.sv ====
/*
  One DMA channel with address reload and indirect source addressing,
  with an AXI4-Lite register slave. Assumes a single-outstanding system bus
  whose access completes with a done pulse, and a bus grant from the arbiter.
*/
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dmari_channel
  import dmari_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Peripheral request and flag clear
  input  wire logic                  xferReq,
  output logic                       reqFlagClear,
  // System bus
  output logic                       busRequest,
  input  wire logic                  busGrant,
  output dmari_pkg::dmari_mreq_s     memReq,
  input  wire dmari_pkg::dmari_mrsp_s memRsp,
  // Completion
  output logic                       endIrq
);
  import dmari_pkg::*;

  typedef enum {ST_IDLE, ST_WAIT, ST_PTR, ST_READ, ST_WRITE, ST_NEXT} dmari_state_e;

  logic [31:0] source_address_reg, srcStart_reg, dest_address_reg;
  logic [31:0] transfer_count_reg, channel_control_reg, dma_operation_reg;
  logic [31:0] dataAddr_reg, data_reg;
  logic [1:0]  group_reg;
  logic        busRequest_reg, irq_reg, flagClr_reg;
  dmari_state_e state_reg;
  dmari_mreq_s  memReq_reg;

  logic awHeld, wHeld;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        doWrite;
  logic [31:0] rdNext;

  wire reloadOn = channel_control_reg[CTRL_RELOAD_BIT];
  wire burstOn  = channel_control_reg[CTRL_BURST_BIT];
  wire indirOn  = channel_control_reg[CTRL_INDIR_BIT];
  wire running  = channel_control_reg[CTRL_ENABLE_BIT] & dma_operation_reg[OPER_MASTER_BIT]
                  & (transfer_count_reg != ZERO_WORD);
  wire [1:0] xferSize = {channel_control_reg[CTRL_TS_HI_BIT], channel_control_reg[CTRL_TS_LO_BIT]};
  wire [1:0] srcMode  = {channel_control_reg[CTRL_SM_HI_BIT], channel_control_reg[CTRL_SM_LO_BIT]};
  wire [1:0] dstMode  = {channel_control_reg[CTRL_DM_HI_BIT], channel_control_reg[CTRL_DM_LO_BIT]};

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] mode,
                                            input logic [1:0] sz);
    logic [31:0] amt;
    amt = 32'h0000_0001 << sz;
    case (mode)
      STEP_INC: step_addr = a + amt;
      STEP_DEC: step_addr = a - amt;
      default:  step_addr = a;
    endcase
  endfunction

  function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge_word = old;
  endfunction

  // Register slave: address and data may arrive in either order
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= ZERO_WORD;
      wStrb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld     <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld     <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == SRC_ADDR_OFS) || (a == DST_ADDR_OFS) || (a == COUNT_OFS)
                || (a == CTRL_OFS) || (a == OPER_OFS);
  endfunction

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_ofs(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    case (s_axi_araddr)
      SRC_ADDR_OFS: rdNext = source_address_reg;
      DST_ADDR_OFS: rdNext = dest_address_reg;
      COUNT_OFS:    rdNext = transfer_count_reg;
      CTRL_OFS:     rdNext = channel_control_reg;
      OPER_OFS:     rdNext = dma_operation_reg;
      default:      rdNext = ZERO_WORD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= ZERO_WORD;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdNext;
      s_axi_rresp  <= known_ofs(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  wire wrSrc  = doWrite && awAddr_reg == SRC_ADDR_OFS;
  wire wrDst  = doWrite && awAddr_reg == DST_ADDR_OFS;
  wire wrCnt  = doWrite && awAddr_reg == COUNT_OFS;
  wire wrCtrl = doWrite && awAddr_reg == CTRL_OFS;
  wire wrOper = doWrite && awAddr_reg == OPER_OFS;

  // Transfer engine
  wire lastInGroup = reloadOn && group_reg == GROUP_LAST;
  wire countLast   = transfer_count_reg == COUNT_ONE;
  wire xferDone    = state_reg == ST_WRITE && memRsp.done;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ST_IDLE;
      busRequest_reg <= 1'b0;
      memReq_reg     <= '0;
      dataAddr_reg   <= ZERO_WORD;
      data_reg       <= ZERO_WORD;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (running && xferReq) begin
            busRequest_reg <= 1'b1;
            state_reg      <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (busGrant) begin
            memReq_reg.valid <= 1'b1;
            memReq_reg.write <= 1'b0;
            memReq_reg.addr  <= source_address_reg;
            if (indirOn) begin
              memReq_reg.size <= SZ_LONG;
              state_reg       <= ST_PTR;
            end else begin
              memReq_reg.size <= xferSize;
              state_reg       <= ST_READ;
            end
          end
        end
        ST_PTR: begin
          memReq_reg.valid <= 1'b0;
          if (memRsp.done) begin
            // Pointer value becomes the real source address
            dataAddr_reg     <= memRsp.rdata;
            memReq_reg.valid <= 1'b1;
            memReq_reg.addr  <= memRsp.rdata;
            memReq_reg.size  <= xferSize;
            state_reg        <= ST_READ;
          end
        end
        ST_READ: begin
          memReq_reg.valid <= 1'b0;
          if (memRsp.done) begin
            data_reg         <= memRsp.rdata;
            memReq_reg.valid <= 1'b1;
            memReq_reg.write <= 1'b1;
            memReq_reg.addr  <= dest_address_reg;
            memReq_reg.size  <= xferSize;
            memReq_reg.wdata <= memRsp.rdata;
            state_reg        <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          memReq_reg.valid <= 1'b0;
          if (memRsp.done) begin
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          // Burst keeps the bus unless the group or the count ended or the channel stopped running
          if (transfer_count_reg == ZERO_WORD || !running || group_reg == GROUP_ZERO
              && reloadOn) begin
            busRequest_reg <= 1'b0;
            state_reg      <= ST_IDLE;
          end else if (burstOn) begin
            state_reg <= ST_WAIT;
          end else begin
            busRequest_reg <= 1'b0;
            state_reg      <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Addresses, count and group position
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      source_address_reg <= ZERO_WORD;
      srcStart_reg       <= ZERO_WORD;
    end else if (wrSrc) begin
      source_address_reg <= merge_word(source_address_reg, wData_reg, wStrb_reg);
      srcStart_reg       <= merge_word(source_address_reg, wData_reg, wStrb_reg);
    end else if (xferDone) begin
      if (lastInGroup) begin
        source_address_reg <= srcStart_reg;
      end else begin
        // Indirect step follows the longword pointer size
        source_address_reg <= step_addr(source_address_reg, srcMode,
                                        indirOn ? SZ_LONG : xferSize);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dest_address_reg <= ZERO_WORD;
    end else if (wrDst) begin
      dest_address_reg <= merge_word(dest_address_reg, wData_reg, wStrb_reg);
    end else if (xferDone) begin
      dest_address_reg <= step_addr(dest_address_reg, dstMode, xferSize);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      transfer_count_reg <= ZERO_WORD;
      group_reg          <= GROUP_ZERO;
    end else if (wrCnt) begin
      transfer_count_reg <= merge_word(transfer_count_reg, wData_reg, wStrb_reg);
      group_reg          <= GROUP_ZERO;
    end else if (xferDone) begin
      transfer_count_reg <= transfer_count_reg - COUNT_ONE;
      group_reg          <= group_reg + 2'h1;
    end
  end

  // Done flag: hardware set wins over software clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      channel_control_reg <= ZERO_WORD;
    end else begin
      if (wrCtrl) begin
        channel_control_reg <= merge_word(channel_control_reg, wData_reg, wStrb_reg)
                               & (CTRL_WMASK | (channel_control_reg
                               & (32'h0000_0001 << CTRL_DONE_BIT)));
      end
      if (xferDone && countLast) begin
        channel_control_reg[CTRL_DONE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dma_operation_reg <= ZERO_WORD;
    end else if (wrOper) begin
      dma_operation_reg <= merge_word(dma_operation_reg, wData_reg, wStrb_reg)
                           & (32'h0000_0001 << OPER_MASTER_BIT);
    end
  end

  // Flag clear at count end or reload group end; interrupt only at count end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flagClr_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      flagClr_reg <= xferDone && (countLast || lastInGroup);
      if (xferDone && countLast && channel_control_reg[CTRL_IE_BIT]) begin
        irq_reg <= 1'b1;
      end else if (!channel_control_reg[CTRL_DONE_BIT] || !channel_control_reg[CTRL_IE_BIT]) begin
        irq_reg <= 1'b0;
      end
    end
  end

  assign busRequest   = busRequest_reg;
  assign memReq       = memReq_reg;
  assign reqFlagClear = flagClr_reg;
  assign endIrq       = irq_reg;

endmodule

// ==== sim/dmari_channel_sva.sv ====
/*
  Port checker for the reload and indirect-address DMA channel.
  Assumes the single clock and active-low reset of dmari_channel.
*/
`timescale 1ns/1ps
module dmari_channel_sva
  import dmari_pkg::*;
(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  // System bus and peripheral side
  input wire logic                   busRequest,
  input wire logic                   busGrant,
  input wire dmari_pkg::dmari_mreq_s memReq,
  input wire dmari_pkg::dmari_mrsp_s memRsp,
  input wire logic                   reqFlagClear,
  input wire logic                   endIrq,
  // Register bus handshakes
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_reset_quiet: assert property ($rose(resetn) |-> !busRequest && !endIrq)
    else $error("Bus request or interrupt active after reset");
  a_access_owned: assert property (memReq.valid |-> busRequest && busGrant)
    else $error("Access issued without bus ownership");
  a_access_pulse: assert property (memReq.valid |=> !memReq.valid)
    else $error("Access strobe longer than one cycle");
  a_write_follows: assert property (memReq.valid && memReq.write |-> $past(memRsp.done))
    else $error("Write not issued right after a read completed");
  a_flag_pulse: assert property (reqFlagClear |=> !reqFlagClear)
    else $error("Flag clear longer than one cycle");
  a_flag_cause: assert property (reqFlagClear |->
      $past(memRsp.done, 1) || $past(memRsp.done, 2) || $past(memRsp.done, 3))
    else $error("Flag clear without a completed transfer");
  a_bus_release: assert property (reqFlagClear |-> ##[0:3] !busRequest)
    else $error("Bus not released after flag clear");
  a_irq_cause: assert property ($rose(endIrq) |->
      $past(memRsp.done, 1) || $past(memRsp.done, 2) || $past(memRsp.done, 3))
    else $error("End interrupt without a completed transfer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data not returned the cycle after address");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped before accepted");
endmodule

bind dmari_channel dmari_channel_sva chk_u (.ref_clk, .resetn, .busRequest, .busGrant,
  .memReq, .memRsp, .reqFlagClear, .endIrq, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ==== sim/dmari_sysbus_model.sv ====
/*
  Arbiter and memory model on the channel's system bus.
  Grants after a random wait; read data is the address plus a fixed offset.
*/
`timescale 1ns/1ps
module dmari_sysbus_model
  import dmari_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  // Bus side
  input  wire logic                   busRequest,
  output logic                        busGrant,
  input  wire dmari_pkg::dmari_mreq_s memReq,
  output dmari_pkg::dmari_mrsp_s      memRsp
);
  import dmari_pkg::*;
  logic [1:0]  waitCnt;
  logic        pend;
  logic [31:0] addrHeld;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) busGrant <= 1'h0;
    else if (!busRequest) busGrant <= 1'h0;
    else if ($urandom_range(1, 0) == 1) busGrant <= 1'h1;
  end

  // Data toggles outside the done cycle so a late sample never matches
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend   <= 1'h0;
      memRsp <= '0;
    end else begin
      memRsp.done <= 1'h0;
      memRsp.rdata <= ~memRsp.rdata;
      waitCnt <= waitCnt - 2'h1;
      if (memReq.valid) begin
        pend     <= 1'h1;
        waitCnt  <= 2'($urandom_range(3, 0));
        addrHeld <= memReq.addr;
      end else if (pend && waitCnt == 2'h0) begin
        pend         <= 1'h0;
        memRsp.done  <= 1'h1;
        memRsp.rdata <= addrHeld + 32'h1000_0000;
      end
    end
  end
endmodule

// ==== sim/dma_reload_indirect_addressing_tb.sv ====
/*
  Self-checking bench for dmari_channel: AXI4-Lite master, queues of
  expected accesses and reads, system bus model on the far side.
*/
`timescale 1ns/1ps
module dma_reload_indirect_addressing_tb;
  import dmari_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [31:0] adr;
    logic [1:0]  sz;
    logic [31:0] dat;
    logic        chk;
  } dmari_exp_s;
  logic        ref_clk, resetn, xferReq, reqFlagClear, busRequest, busGrant, endIrq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, base;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  dmari_mreq_s memReq;
  dmari_mrsp_s memRsp;
  dmari_exp_s  expQ[$];
  dmari_exp_s  ex;
  logic [33:0] rdQ[$];
  logic [33:0] rx;
  int          mismatches, samples_checked, g, k;

  dmari_channel dut_u (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xferReq, .reqFlagClear, .busRequest,
    .busGrant, .memReq, .memRsp, .endIrq);
  dmari_sysbus_model bus_u (.ref_clk, .resetn, .busRequest, .busGrant, .memReq, .memRsp);

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task stuck(input string nm);
    cmp(nm, 32'h0000_0001, 32'h0000_0000);
    tally_and_finish;
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        cmp("write resp", RESP_OKAY, s_axi_bresp);
        break;
      end
    end
    s_axi_bready <= 1'h0;
    if (n == 100) stuck("write response");
  endtask

  task axr(input logic [7:0] a, input logic [33:0] e);
    int n;
    rdQ.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 100) stuck("read data");
  endtask

  // Indirect data sits at the pointer plus the model's offset
  task xfer(input logic [31:0] s, input logic [31:0] d, input logic [1:0] z, input logic ind);
    if (ind) expQ.push_back({1'h0, s, SZ_LONG, ZERO_WORD, 1'h0});
    expQ.push_back({1'h0, ind ? s + 32'h1000_0000 : s, z, ZERO_WORD, 1'h0});
    expQ.push_back({1'h1, d, z, s + (ind ? 32'h2000_0000 : 32'h1000_0000), z == SZ_LONG});
  endtask

  task run_until_clear;
    int n;
    xferReq <= 1'h1;
    for (n = 0; n < 3000 && reqFlagClear !== 1'h1; n++) @(posedge ref_clk);
    if (n == 3000) stuck("flag clear");
    repeat (4) @(posedge ref_clk);
    cmp("pending accesses", 32'h0000_0000, expQ.size());
  endtask

  // Peripheral drops its request once the channel clears its flag
  always @(posedge ref_clk) if (reqFlagClear) xferReq <= 1'h0;

  always @(posedge ref_clk) begin
    if (memReq.valid === 1'h1) begin
      if (expQ.size() == 0) begin
        stuck("unexpected access");
      end else begin
        ex = expQ.pop_front();
        cmp("write flag", ex.wr, memReq.write);
        cmp("address", ex.adr, memReq.addr);
        cmp("size", ex.sz, memReq.size);
        if (ex.chk) cmp("write data", ex.dat, memReq.wdata);
      end
    end
    if (s_axi_rvalid === 1'h1 && s_axi_rready) begin
      rx = rdQ.pop_front();
      cmp("read data", rx[31:0], s_axi_rdata);
      cmp("read resp", rx[33:32], s_axi_rresp);
    end
  end

  initial begin
    {resetn, xferReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    mismatches = 0;
    samples_checked = 0;
    base = $urandom(56647);
    repeat (20) @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    cmp("busRequest", 32'h0000_0000, busRequest);
    axw(SRC_ADDR_OFS, 32'h0000_0100);
    axr(SRC_ADDR_OFS, {RESP_OKAY, 32'h0000_0100});
    axr(8'h14, {RESP_SLVERR, ZERO_WORD});
    axw(OPER_OFS, 32'h0000_0001);
    // Reload on, burst, long, source up, dest down, eight transfers
    axw(DST_ADDR_OFS, 32'h0000_0800);
    axw(COUNT_OFS, 32'h0000_0008);
    axw(CTRL_OFS, 32'h0000_0675);
    for (g = 0; g < 2; g++) begin
      for (k = 0; k < 4; k++) xfer(32'h0000_0100 + k * 4, 32'h0000_0800 - (g * 4 + k) * 4, SZ_LONG, 1'h0);
      run_until_clear();
      cmp("endIrq", g, endIrq);
      axr(COUNT_OFS, {RESP_OKAY, 32'h0000_0004 - g * 4});
      axr(SRC_ADDR_OFS, {RESP_OKAY, 32'h0000_0100});
      axr(DST_ADDR_OFS, {RESP_OKAY, 32'h0000_0800 - (g + 1) * 16});
    end
    // Reload off: five back to back in one burst from a random base
    base = base & 32'h0FFF_FFF0;
    axw(SRC_ADDR_OFS, base);
    axw(COUNT_OFS, 32'h0000_0005);
    axw(CTRL_OFS, 32'h0000_0531);
    for (k = 0; k < 5; k++) xfer(base + k * 4, 32'h0000_07E0 + k * 4, SZ_LONG, 1'h0);
    run_until_clear();
    cmp("endIrq", 32'h0000_0000, endIrq);
    axr(SRC_ADDR_OFS, {RESP_OKAY, base + 32'h0000_0014});
    // Indirect, byte, cycle-steal, fixed destination
    axw(SRC_ADDR_OFS, 32'h0000_0200);
    axw(DST_ADDR_OFS, 32'h0000_0900);
    axw(COUNT_OFS, 32'h0000_0002);
    axw(CTRL_OFS, 32'h0000_0481);
    xfer(32'h0000_0200, 32'h0000_0900, SZ_BYTE, 1'h1);
    xfer(32'h0000_0204, 32'h0000_0900, SZ_BYTE, 1'h1);
    run_until_clear();
    axr(SRC_ADDR_OFS, {RESP_OKAY, 32'h0000_0208});
    axr(DST_ADDR_OFS, {RESP_OKAY, 32'h0000_0900});
    tally_and_finish;
  end
endmodule
